// ### hdl/frcct_pkg.sv
package frcct_pkg;

  // time base width and values
  localparam int                CNT_W      = 16;
  localparam logic [CNT_W-1:0]  COUNT_INIT = 16'h0000;
  localparam logic [CNT_W-1:0]  COUNT_MAX  = 16'hFFFF;
  localparam int                PRESC_W    = 3;

  // register map, byte addresses on the bus
  localparam int          REG_STRIDE       = 4;
  localparam logic [7:0]  TIMER_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  TIMER_COUNT_OFS  = 8'h04;
  localparam logic [7:0]  CAP_CTRL_OFS     = 8'h08;  // lo pair, hi pair at next word
  localparam logic [7:0]  CAP_VAL_OFS      = 8'h10;
  localparam logic [7:0]  CMP_VAL_OFS      = 8'h20;
  localparam logic [7:0]  CMP_OUT_CTRL_OFS = 8'h40;
  localparam logic [7:0]  IRQ_STATUS_OFS   = 8'h50;
  localparam logic [7:0]  IRQ_MASK_OFS     = 8'h54;
  localparam logic [31:0] REG_RESET        = 32'h0000_0000;

  // timer control fields
  localparam int TC_CLK_SEL_LSB  = 0;
  localparam int TC_CLR_MODE_BIT = 2;
  localparam int TC_RUN_BIT      = 3;
  localparam int TC_OVF_FLAG_BIT = 4;
  localparam int TC_OVF_IE_BIT   = 5;

  // capture control fields, per pair, second channel one slot up
  localparam int EDGE_W      = 2;
  localparam int CC_EDGE_LSB = 0;
  localparam int CC_IE_LSB   = 4;
  localparam int CC_FLAG_LSB = 6;

  // compare output control fields, per pair
  localparam int OC_RUN_LSB   = 0;
  localparam int OC_IE_LSB    = 4;
  localparam int OC_FLAG_LSB  = 6;
  localparam int OC_LEVEL_LSB = 8;
  localparam int OC_PAIR_BIT  = 12;

  // interrupt status and mask layout
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_CAP_LSB = 1;
  localparam int STAT_CMP_LSB = 5;

  // capture edge selections
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

endpackage

// ### hdl/frcct_top.sv
`timescale 1ns/1ps
module frcct_top
  import frcct_pkg::*;
#(
  parameter int N_CAP = 4,  // at most 4 fit the map
  parameter int N_CMP = 8   // even, at most 8
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // avalon-mm slave
  input  wire logic [7:0]         address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [31:0]        writedata,
  input  wire logic [3:0]         byteenable,
  output logic      [31:0]        readdata,
  output logic                    waitrequest,
  // pins
  input  wire logic [N_CAP-1:0]   cap_in,
  output logic      [N_CMP-1:0]   cmp_out,
  // interrupt
  output logic                    irq
);

  localparam int NCP = (N_CAP + 1) / 2;
  localparam int NOP = N_CMP / 2;

  // bus state
  logic             wait_r;
  logic [31:0]      readdata_r;
  logic             irq_r;
  // time base
  logic [CNT_W-1:0]   cnt_r;
  logic [PRESC_W-1:0] presc_r;
  logic               cnt_new_r;
  logic [1:0]         clk_sel_r;
  logic               clr_mode_r;
  logic               run_r;
  logic               ovf_flag_r;
  logic               ovf_ie_r;
  // capture
  logic [N_CAP-1:0]   cap_s1_r;
  logic [N_CAP-1:0]   cap_s2_r;
  logic [N_CAP-1:0]   cap_s3_r;
  logic [N_CAP-1:0]   cap_flag_r;
  logic [N_CAP-1:0]   cap_ie_r;
  logic [1:0]         cap_edge_r [N_CAP];
  logic [CNT_W-1:0]   cap_val_r  [N_CAP];
  // compare
  logic [CNT_W-1:0]   cmp_val_r  [N_CMP];
  logic [N_CMP-1:0]   cmp_run_r;
  logic [N_CMP-1:0]   cmp_ie_r;
  logic [N_CMP-1:0]   cmp_flag_r;
  logic [N_CMP-1:0]   out_lvl_r;
  logic [NOP-1:0]     pair_mode_r;

  // byte enables to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int k = 0; k < 4; k++) begin
      m[8*k +: 8] = {8{be[k]}};
    end
    return m;
  endfunction

  // prescaler tap: sel n gives one tick every 2**n clocks
  function automatic logic presc_tick(input logic [PRESC_W-1:0] p, input logic [1:0] sel);
    logic [PRESC_W-1:0] m;
    m = PRESC_W'((1 << sel) - 1);
    return (p & m) == m;
  endfunction

  // address match for the idx-th word of a register array
  function automatic logic is_slot(input logic [7:0] a, input logic [7:0] base, input int idx);
    return a == 8'(int'(base) + idx * REG_STRIDE);
  endfunction

  // access decode
  logic              acc_wr;
  logic [31:0]       wmask;
  logic [31:0]       rd_val;
  logic [31:0]       wr_eff;
  logic [31:0]       wr_stat;
  logic              wr_tc;
  logic              wr_stat_sel;
  logic              wr_mask_sel;
  logic [NCP-1:0]    wr_cap_ctrl;
  logic [NOP-1:0]    wr_cmp_ctrl;
  logic [N_CMP-1:0]  wr_cmp_val;
  logic [31:0]       cap_ctrl_w [NCP];
  logic [31:0]       cmp_ctrl_w [NOP];
  logic [31:0]       stat_vec;
  logic [31:0]       mask_vec;

  // packed views of the control words and flags
  always_comb begin
    stat_vec = REG_RESET;
    mask_vec = REG_RESET;
    stat_vec[STAT_OVF_BIT] = ovf_flag_r;
    mask_vec[STAT_OVF_BIT] = ovf_ie_r;
    stat_vec[STAT_CAP_LSB +: N_CAP] = cap_flag_r;
    mask_vec[STAT_CAP_LSB +: N_CAP] = cap_ie_r;
    stat_vec[STAT_CMP_LSB +: N_CMP] = cmp_flag_r;
    mask_vec[STAT_CMP_LSB +: N_CMP] = cmp_ie_r;
    for (int p = 0; p < NCP; p++) begin
      cap_ctrl_w[p] = REG_RESET;
    end
    for (int i = 0; i < N_CAP; i++) begin
      cap_ctrl_w[i/2][CC_EDGE_LSB + EDGE_W*(i%2) +: EDGE_W] = cap_edge_r[i];
      cap_ctrl_w[i/2][CC_IE_LSB + i%2]                      = cap_ie_r[i];
      cap_ctrl_w[i/2][CC_FLAG_LSB + i%2]                    = cap_flag_r[i];
    end
    for (int p = 0; p < NOP; p++) begin
      cmp_ctrl_w[p] = REG_RESET;
      cmp_ctrl_w[p][OC_PAIR_BIT] = pair_mode_r[p];
      for (int s = 0; s < 2; s++) begin
        cmp_ctrl_w[p][OC_RUN_LSB + s]   = cmp_run_r[2*p+s];
        cmp_ctrl_w[p][OC_IE_LSB + s]    = cmp_ie_r[2*p+s];
        cmp_ctrl_w[p][OC_FLAG_LSB + s]  = cmp_flag_r[2*p+s];
        cmp_ctrl_w[p][OC_LEVEL_LSB + s] = out_lvl_r[2*p+s];
      end
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    rd_val = REG_RESET;
    if (address == TIMER_CTRL_OFS) begin
      rd_val[TC_CLK_SEL_LSB +: 2] = clk_sel_r;
      rd_val[TC_CLR_MODE_BIT]     = clr_mode_r;
      rd_val[TC_RUN_BIT]          = run_r;
      rd_val[TC_OVF_FLAG_BIT]     = ovf_flag_r;
      rd_val[TC_OVF_IE_BIT]       = ovf_ie_r;
    end
    if (address == TIMER_COUNT_OFS) begin
      rd_val[CNT_W-1:0] = cnt_r;
    end
    if (address == IRQ_STATUS_OFS) begin
      rd_val = stat_vec;
    end
    if (address == IRQ_MASK_OFS) begin
      rd_val = mask_vec;
    end
    for (int p = 0; p < NCP; p++) begin
      if (is_slot(address, CAP_CTRL_OFS, p)) begin
        rd_val = cap_ctrl_w[p];
      end
    end
    for (int i = 0; i < N_CAP; i++) begin
      if (is_slot(address, CAP_VAL_OFS, i)) begin
        rd_val[CNT_W-1:0] = cap_val_r[i];
      end
    end
    for (int j = 0; j < N_CMP; j++) begin
      if (is_slot(address, CMP_VAL_OFS, j)) begin
        rd_val[CNT_W-1:0] = cmp_val_r[j];
      end
    end
    for (int p = 0; p < NOP; p++) begin
      if (is_slot(address, CMP_OUT_CTRL_OFS, p)) begin
        rd_val = cmp_ctrl_w[p];
      end
    end
  end

  // write strobes; disabled lanes keep the old value, so flags there are not cleared
  always_comb begin
    acc_wr      = write && !wait_r;
    wmask       = lane_mask(byteenable);
    wr_eff      = (rd_val & ~wmask) | (writedata & wmask);
    wr_stat     = writedata & wmask;
    wr_tc       = acc_wr && (address == TIMER_CTRL_OFS);
    wr_stat_sel = acc_wr && (address == IRQ_STATUS_OFS);
    wr_mask_sel = acc_wr && (address == IRQ_MASK_OFS);
    for (int p = 0; p < NCP; p++) begin
      wr_cap_ctrl[p] = acc_wr && is_slot(address, CAP_CTRL_OFS, p);
    end
    for (int p = 0; p < NOP; p++) begin
      wr_cmp_ctrl[p] = acc_wr && is_slot(address, CMP_OUT_CTRL_OFS, p);
    end
    for (int j = 0; j < N_CMP; j++) begin
      wr_cmp_val[j] = acc_wr && is_slot(address, CMP_VAL_OFS, j);
    end
  end

  // bus handshake: one wait cycle, then completion; keeps outputs registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r     <= 1'b1;
      readdata_r <= REG_RESET;
    end else begin
      wait_r <= !((read || write) && wait_r);
      if (read && wait_r) begin
        readdata_r <= rd_val;
      end
    end
  end

  // time base events
  logic              tick;
  logic              clr_hit;
  logic              ovf_evt;
  logic [N_CAP-1:0]  cap_evt;
  logic [N_CMP-1:0]  cmp_hit;
  logic [N_CMP-1:0]  cmp_tgl;

  always_comb begin
    tick    = run_r && presc_tick(presc_r, clk_sel_r);
    clr_hit = clr_mode_r && (cnt_r == cmp_val_r[0]);
    ovf_evt = tick && !clr_hit && (cnt_r == COUNT_MAX);
  end

  // timer control register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_sel_r  <= 2'h0;
      clr_mode_r <= 1'b0;
      run_r      <= 1'b0;
      ovf_ie_r   <= 1'b0;
    end else if (wr_tc) begin
      clk_sel_r  <= wr_eff[TC_CLK_SEL_LSB +: 2];
      clr_mode_r <= wr_eff[TC_CLR_MODE_BIT];
      run_r      <= wr_eff[TC_RUN_BIT];
      ovf_ie_r   <= wr_eff[TC_OVF_IE_BIT];
    end else if (wr_mask_sel) begin
      ovf_ie_r   <= wr_eff[STAT_OVF_BIT];
    end
  end

  // shared up counter; prescaler restarts while stopped so the first tick is whole
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r     <= COUNT_INIT;
      presc_r   <= '0;
      cnt_new_r <= 1'b0;
    end else begin
      presc_r   <= run_r ? presc_r + 1'b1 : '0;
      cnt_new_r <= tick;
      if (tick) begin
        cnt_r <= clr_hit ? COUNT_INIT : cnt_r + 1'b1;
      end
    end
  end

  // overflow flag, set beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_flag_r <= 1'b0;
    end else begin
      ovf_flag_r <= ovf_evt || (ovf_flag_r && !(wr_tc && !wr_eff[TC_OVF_FLAG_BIT])
                                           && !(wr_stat_sel && wr_stat[STAT_OVF_BIT]));
    end
  end

  // two-stage synchroniser plus a history stage for edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_s1_r <= '0;
      cap_s2_r <= '0;
      cap_s3_r <= '0;
    end else begin
      cap_s1_r <= cap_in;
      cap_s2_r <= cap_s1_r;
      cap_s3_r <= cap_s2_r;
    end
  end

  // edge qualification, each pin on its own
  always_comb begin
    for (int i = 0; i < N_CAP; i++) begin
      case (cap_edge_r[i])
        EDGE_RISE: cap_evt[i] = cap_s2_r[i] && !cap_s3_r[i];
        EDGE_FALL: cap_evt[i] = !cap_s2_r[i] && cap_s3_r[i];
        EDGE_BOTH: cap_evt[i] = cap_s2_r[i] != cap_s3_r[i];
        default:   cap_evt[i] = 1'b0;
      endcase
    end
  end

  // capture configuration
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_ie_r <= '0;
      for (int i = 0; i < N_CAP; i++) begin
        cap_edge_r[i] <= EDGE_NONE;
      end
    end else begin
      for (int i = 0; i < N_CAP; i++) begin
        if (wr_cap_ctrl[i/2]) begin
          cap_edge_r[i] <= wr_eff[CC_EDGE_LSB + EDGE_W*(i%2) +: EDGE_W];
          cap_ie_r[i]   <= wr_eff[CC_IE_LSB + i%2];
        end else if (wr_mask_sel) begin
          cap_ie_r[i]   <= wr_eff[STAT_CAP_LSB + i];
        end
      end
    end
  end

  // latch the count on a valid edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N_CAP; i++) begin
        cap_val_r[i] <= COUNT_INIT;
      end
    end else begin
      for (int i = 0; i < N_CAP; i++) begin
        if (cap_evt[i]) begin
          cap_val_r[i] <= cnt_r;
        end
      end
    end
  end

  // capture flags; zero clears, one keeps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_flag_r <= '0;
    end else begin
      for (int i = 0; i < N_CAP; i++) begin
        cap_flag_r[i] <= cap_evt[i] || (cap_flag_r[i]
                         && !(wr_cap_ctrl[i/2] && !wr_eff[CC_FLAG_LSB + i%2])
                         && !(wr_stat_sel && wr_stat[STAT_CAP_LSB + i]));
      end
    end
  end

  // match only once per new count, so a slow count clock gives one toggle
  always_comb begin
    for (int j = 0; j < N_CMP; j++) begin
      cmp_hit[j] = cmp_run_r[j] && cnt_new_r && (cnt_r == cmp_val_r[j]);
    end
    for (int j = 0; j < N_CMP; j++) begin
      // paired: even pin follows both, odd pin holds
      if (pair_mode_r[j/2]) begin
        cmp_tgl[j] = (j % 2 == 0) ? (cmp_hit[j] || cmp_hit[j | 1]) : 1'b0;  // j | 1 never leaves the range
      end else begin
        cmp_tgl[j] = cmp_hit[j];
      end
    end
  end

  // compare values
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int j = 0; j < N_CMP; j++) begin
        cmp_val_r[j] <= COUNT_INIT;
      end
    end else begin
      for (int j = 0; j < N_CMP; j++) begin
        if (wr_cmp_val[j]) begin
          cmp_val_r[j] <= wr_eff[CNT_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_run_r   <= '0;
      cmp_ie_r    <= '0;
      pair_mode_r <= '0;
    end else begin
      for (int p = 0; p < NOP; p++) begin
        if (wr_cmp_ctrl[p]) begin
          pair_mode_r[p] <= wr_eff[OC_PAIR_BIT];
        end
      end
      for (int j = 0; j < N_CMP; j++) begin
        if (wr_cmp_ctrl[j/2]) begin
          cmp_run_r[j] <= wr_eff[OC_RUN_LSB + j%2];
          cmp_ie_r[j]  <= wr_eff[OC_IE_LSB + j%2];
        end else if (wr_mask_sel) begin
          cmp_ie_r[j]  <= wr_eff[STAT_CMP_LSB + j];
        end
      end
    end
  end

  // output latches; a toggle in the cycle of a level write wins, no event is lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_lvl_r <= '0;
    end else begin
      for (int j = 0; j < N_CMP; j++) begin
        if (cmp_tgl[j]) begin
          out_lvl_r[j] <= !out_lvl_r[j];
        end else if (wr_cmp_ctrl[j/2]) begin
          out_lvl_r[j] <= wr_eff[OC_LEVEL_LSB + j%2];
        end
      end
    end
  end

  // match flags; zero clears, one keeps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_flag_r <= '0;
    end else begin
      for (int j = 0; j < N_CMP; j++) begin
        cmp_flag_r[j] <= cmp_hit[j] || (cmp_flag_r[j]
                         && !(wr_cmp_ctrl[j/2] && !wr_eff[OC_FLAG_LSB + j%2])
                         && !(wr_stat_sel && wr_stat[STAT_CMP_LSB + j]));
      end
    end
  end

  // level interrupt from unmasked flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stat_vec & mask_vec);
    end
  end

  // outputs straight from flops
  assign readdata    = readdata_r;
  assign waitrequest = wait_r;
  assign cmp_out     = out_lvl_r;
  assign irq         = irq_r;

endmodule // frcct_top

// ### dv/frcct_assertions.sv
`timescale 1ns/1ps
module frcct_assertions
  import frcct_pkg::*;
#(
  parameter int N_CAP = 4,
  parameter int N_CMP = 8
) (
  // clock and reset
  input wire logic             clk,
  input wire logic             rst_n,
  // bus
  input wire logic [7:0]       address,
  input wire logic             read,
  input wire logic             write,
  input wire logic [31:0]      writedata,
  input wire logic [3:0]       byteenable,
  input wire logic [31:0]      readdata,
  input wire logic             waitrequest,
  // pins and interrupt
  input wire logic [N_CAP-1:0] cap_in,
  input wire logic [N_CMP-1:0] cmp_out,
  input wire logic             irq
);
  logic       wr_done;
  logic [1:0] run0_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // a write completes where waitrequest is low
  assign wr_done = write && !waitrequest;

  // pair 0 run bits as last written; a level load is judged only while they are off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run0_r <= 2'h0;
    end else if (wr_done && address == CMP_OUT_CTRL_OFS && byteenable[0]) begin
      run0_r <= writedata[1:0];
    end
  end

  a_wait_one_cycle: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_after_req: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  a_idle_wait_high: assert property (!(read || write) |=> waitrequest)
    else $error("waitrequest low without a request");
  a_reset_quiet: assert property ($rose(rst_n) |-> waitrequest && !irq && cmp_out == '0 && readdata == '0)
    else $error("outputs not at reset values after reset");
  a_unmapped_zero: assert property (read && waitrequest && address == 8'h60 |=> readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_upper_half_zero: assert property (read && waitrequest && address >= CAP_VAL_OFS && address < CMP_OUT_CTRL_OFS
                                      |=> readdata[31:16] == 16'h0000)
    else $error("upper half of a 16 bit value not zero");
  a_read_data_stands: assert property ($changed(readdata) |-> $past(read && waitrequest))
    else $error("readdata changed without a read");
  a_mask_off_irq: assert property (wr_done && address == IRQ_MASK_OFS && byteenable == 4'hf &&
                                   writedata == 32'h0000_0000 |=> ##1 !irq)
    else $error("irq high two cycles after mask cleared");
  a_level_load: assert property (wr_done && address == CMP_OUT_CTRL_OFS && byteenable[1] && run0_r == 2'h0 &&
                                 writedata[1:0] == 2'h0 |=> cmp_out[1:0] == $past(writedata[9:8]))
    else $error("compare latch not loaded by level write");
endmodule // frcct_assertions

bind frcct_top frcct_assertions #(.N_CAP(N_CAP), .N_CMP(N_CMP)) u_chk (.clk(clk), .rst_n(rst_n),
  .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest), .cap_in(cap_in), .cmp_out(cmp_out), .irq(irq));

// ### dv/frcct_pin_model.sv
`timescale 1ns/1ps
module frcct_pin_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // wanted pin levels
  input  wire logic [3:0] level_req,
  // capture pins
  output logic      [3:0] cap_in
);
  // external source moves its pins just after an edge, unrelated to the bus
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_in <= 4'h0;
    end else begin
      cap_in <= level_req;
    end
  end
endmodule // frcct_pin_model

// ### dv/frcct_tb_top.sv
`timescale 1ns/1ps
module frcct_tb_top;
  import frcct_pkg::*;

  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [3:0] be; logic [31:0] q;} frcct_row_t;

  localparam frcct_row_t ROWS [12] = '{
    '{CMP_VAL_OFS, 32'h1234_abcd, 4'hf, 32'h0000_abcd},
    '{CMP_VAL_OFS, 32'h0000_5599, 4'h2, 32'h0000_55cd},
    '{CMP_VAL_OFS + 8'h1c, 32'h0000_ffff, 4'hf, 32'h0000_ffff},
    '{TIMER_CTRL_OFS, 32'h0000_0027, 4'hf, 32'h0000_0027},
    '{TIMER_COUNT_OFS, 32'h0000_ffff, 4'hf, 32'h0000_0000},
    '{CAP_VAL_OFS + 8'h0c, 32'h0000_1111, 4'hf, 32'h0000_0000},
    '{CAP_CTRL_OFS, 32'h0000_00ff, 4'hf, 32'h0000_003f},
    '{IRQ_MASK_OFS, 32'hffff_ffff, 4'hf, 32'h0000_1fff},
    '{CMP_OUT_CTRL_OFS, 32'h0000_0300, 4'hf, 32'h0000_0300},
    '{8'h60, 32'h0000_ffff, 4'hf, 32'h0000_0000},
    '{IRQ_STATUS_OFS, 32'hffff_ffff, 4'hf, 32'h0000_0000},
    '{IRQ_MASK_OFS, 32'h0000_0000, 4'hf, 32'h0000_0000}};

  // design ports
  logic        clk;
  logic        rst_n;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [3:0]  cap_in;
  logic [7:0]  cmp_out;
  logic        irq;
  // bench state
  logic [3:0]  level_req;
  logic [31:0] rdata;
  logic [31:0] c0;
  logic [31:0] c1;
  int          num_errors;
  int          comparisons;
  int          cycles;
  int          t[8];
  int          gap;
  int          last;

  frcct_top #(.N_CAP(4), .N_CMP(8)) u_dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .cap_in(cap_in), .cmp_out(cmp_out), .irq(irq));
  frcct_pin_model u_pins (.clk(clk), .rst_n(rst_n), .level_req(level_req), .cap_in(cap_in));

  // 20 MHz clock
  initial clk = 1'b0;
  always #25 clk = ~clk;

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one avalon access; an idle edge follows so no signal is assigned twice in a step
  // no wait limit here: a slave that never answers is ended by the cycle ceiling
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    address    <= a;
    writedata  <= d;
    byteenable <= b;
    read       <= !wr;
    write      <= wr;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    rdata = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // a hang is cut short well after the overflow wait
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    {rst_n, read, write, address, writedata, byteenable, level_req} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // ordinary register cases: write then read back
    foreach (ROWS[i]) begin
      bus(1'b1, ROWS[i].a, ROWS[i].d, ROWS[i].be);
      bus(1'b0, ROWS[i].a, 32'h0, 4'hf);
      check("row", ROWS[i].q, rdata);
      if (i == 8) check("level", 32'h0000_0003, {24'h0, cmp_out});
    end
    // count rate for each of the four selections over 81 edges
    for (int s = 0; s < 4; s++) begin
      bus(1'b0, TIMER_COUNT_OFS, 32'h0, 4'hf);
      c0 = rdata;
      bus(1'b1, TIMER_CTRL_OFS, 32'h0000_0008 | s, 4'hf);
      repeat (78) @(posedge clk);
      bus(1'b1, TIMER_CTRL_OFS, 32'h0000_0000, 4'hf);
      bus(1'b0, TIMER_COUNT_OFS, 32'h0, 4'hf);
      gap = int'(rdata - c0) - (81 >> s);
      check("count_step", 1, {31'h0, gap >= -1 && gap <= 1});
    end
    // capture on a frozen count: ch0 rise, ch1 fall, ch2 both, ch3 none
    c0 = rdata;
    bus(1'b1, IRQ_MASK_OFS, 32'h0000_0002, 4'hf);
    bus(1'b1, CAP_CTRL_OFS, 32'h0000_0019, 4'hf);
    bus(1'b1, CAP_CTRL_OFS + 8'h04, 32'h0000_0003, 4'hf);
    level_req <= 4'hf;
    repeat (6) @(posedge clk);
    bus(1'b0, IRQ_STATUS_OFS, 32'h0, 4'hf);
    check("status_rise", 32'h0000_000a, rdata);
    check("irq_cap", 1, {31'h0, irq});
    bus(1'b1, TIMER_CTRL_OFS, 32'h0000_0008, 4'hf);
    bus(1'b1, TIMER_CTRL_OFS, 32'h0000_0000, 4'hf);
    bus(1'b0, TIMER_COUNT_OFS, 32'h0, 4'hf);
    c1 = rdata;
    level_req <= 4'h0;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, CAP_VAL_OFS + 8'(4 * i), 32'h0, 4'hf);
      check("cap_value", (i == 0) ? c0 : c1, rdata);
    end
    bus(1'b1, CAP_CTRL_OFS, 32'h0000_00d9, 4'hf);
    bus(1'b0, IRQ_STATUS_OFS, 32'h0, 4'hf);
    check("flag_keep", 32'h0000_000e, rdata);
    bus(1'b1, CAP_CTRL_OFS, 32'h0000_0019, 4'hf);
    bus(1'b0, IRQ_STATUS_OFS, 32'h0, 4'hf);
    check("flag_clear", 32'h0000_0008, rdata);
    check("irq_clear", 0, {31'h0, irq});
    // second reset mid-run, then every row place reads its reset value
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (ROWS[i]) begin
      bus(1'b0, ROWS[i].a, 32'h0, 4'hf);
      check("reset", REG_RESET, rdata);
    end
    // compares in clear-on-match mode, pair 1 paired, ch5 alone
    bus(1'b1, CMP_VAL_OFS, 32'h0000_0010, 4'hf);
    bus(1'b1, CMP_VAL_OFS + 8'h08, 32'h0000_0004, 4'hf);
    bus(1'b1, CMP_VAL_OFS + 8'h0c, 32'h0000_000a, 4'hf);
    bus(1'b1, CMP_VAL_OFS + 8'h14, 32'h0000_0008, 4'hf);
    bus(1'b1, CMP_OUT_CTRL_OFS, 32'h0000_0001, 4'hf);
    bus(1'b1, CMP_OUT_CTRL_OFS + 8'h04, 32'h0000_1003, 4'hf);
    bus(1'b1, CMP_OUT_CTRL_OFS + 8'h08, 32'h0000_0002, 4'hf);
    bus(1'b1, IRQ_MASK_OFS, 32'h0000_0020, 4'hf);
    bus(1'b1, TIMER_CTRL_OFS, 32'h0000_000c, 4'hf);
    t = '{default: 0};
    last = 0;
    for (int k = 1; k <= 340; k++) begin
      c0 = {24'h0, cmp_out};
      // read right after the edge: the value settled in the cycle before it
      @(posedge clk);
      for (int j = 0; j < 8; j++) t[j] += int'(c0[j] != cmp_out[j]);
      if (c0[0] != cmp_out[0]) begin
        gap = k - last;
        last = k;
      end
    end
    check("period", 17, gap);
    check("ch0_toggles", 1, {31'h0, t[0] >= 19 && t[0] <= 21});
    check("ch5_toggles", 1, {31'h0, t[5] >= 19 && t[5] <= 21});
    check("pair_toggles", 1, {31'h0, t[2] >= 39 && t[2] <= 41 && t[3] == 0});
    check("irq_cmp", 1, {31'h0, irq});
    bus(1'b1, TIMER_CTRL_OFS, 32'h0000_0004, 4'hf);
    bus(1'b0, TIMER_COUNT_OFS, 32'h0, 4'hf);
    check("clear_bound", 1, {31'h0, rdata <= 32'h0000_0010});
    bus(1'b0, IRQ_STATUS_OFS, 32'h0, 4'hf);
    check("cmp_flags", 32'h0000_05a0, rdata);
    bus(1'b1, IRQ_STATUS_OFS, 32'h0000_05a0, 4'hf);
    bus(1'b0, IRQ_STATUS_OFS, 32'h0, 4'hf);
    check("w1c", 32'h0000_0000, rdata);
    // overflow after a full wrap of the count
    bus(1'b1, IRQ_MASK_OFS, 32'h0000_0001, 4'hf);
    bus(1'b1, TIMER_CTRL_OFS, 32'h0000_0028, 4'hf);
    for (int k = 0; k < 70000 && irq !== 1'b1; k++) @(posedge clk);
    bus(1'b1, TIMER_CTRL_OFS, 32'h0000_0038, 4'hf);
    bus(1'b0, TIMER_CTRL_OFS, 32'h0, 4'hf);
    check("ovf_flag", 32'h0000_0038, rdata);
    bus(1'b1, TIMER_CTRL_OFS, 32'h0000_0020, 4'hf);
    bus(1'b0, TIMER_CTRL_OFS, 32'h0, 4'hf);
    check("ovf_clear", 32'h0000_0020, rdata);
    check("irq_ovf", 0, {31'h0, irq});
    close_out();
  end
endmodule // frcct_tb_top
